// >>> hw/mlsrp_defines.svh
`ifndef MLSRP_DEFINES_SVH
`define MLSRP_DEFINES_SVH

// Sample word and the count of bits that size a source-synchronous read
`define MLSRP_WORD_BITS 20
`define MLSRP_SRC_READ_BITS 18

// Field positions in the output protocol byte
`define MLSRP_MODE_LSB 0
`define MLSRP_MODE_MSB 1
`define MLSRP_WIDTH_LSB 2
`define MLSRP_WIDTH_MSB 3
`define MLSRP_RATE_BIT 4
`define MLSRP_CSRC_LSB 6
`define MLSRP_CSRC_MSB 7

// Field codes
`define MLSRP_MODE_SRC 2'h3
`define MLSRP_WIDTH_DUAL 2'h2
`define MLSRP_WIDTH_QUAD 2'h3
`define MLSRP_CSRC_SCLK 2'h0
`define MLSRP_CFG_CHAIN 8'h00

// Reset values
`define MLSRP_FRAMING_RST 2'h0
`define MLSRP_CFG_RST 8'h00

// Internal clock half period in system clock cycles
`define MLSRP_INT_HALF 4'h1

// Buffer depth
`define MLSRP_BUF_DEPTH 2

`endif

// >>> hw/mlsrp_pkg.sv
`default_nettype none

package mlsrp_pkg;

  // Frame sequencing states
  typedef enum logic [1:0] {
    MLSRP_IDLE,
    MLSRP_SPI,
    MLSRP_SRC
  } mlsrp_state_t;

endpackage : mlsrp_pkg

`default_nettype wire

// >>> hw/mlsrp_word_buffer.sv
`default_nettype none

module mlsrp_word_buffer #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 2
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic in_valid, // Source offers a word
  output logic in_ready, // Buffer can take a word
  input wire logic [WIDTH-1:0] in_data, // Word from source
  output logic out_valid, // Buffer holds a word
  input wire logic out_ready, // Drain takes the head word
  output logic [WIDTH-1:0] out_data // Head word
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] wr_nxt;
  logic [PW-1:0] rd_r;
  logic [PW-1:0] rd_nxt;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count next values
  always_comb
  begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop)
    begin
      rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage, written only on an accepted word
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_r] <= in_data;
    end
  end

endmodule : mlsrp_word_buffer

`default_nettype wire

// >>> hw/mlsrp_readout.sv
`include "mlsrp_defines.svh"

`default_nettype none

// Overview of operation
// - SPI framings can widen to two or four lanes
// - Width 10b drives two bits per launch
// - Width 11b drives four bits per launch
// - Launch edge and first bits follow SPI mode
// - Config 08h dual, 0Ch quad, any framing
// - Return clock held low in SPI framing
// - Nonzero config: zeros follow the word
// - Source-synchronous mode drives output clock with data
// - Clock source: serial, internal, /2, /4
// - Source-synchronous lanes launch on output clock edges
// - Rate bit selects single or double rate
// - Single rate launches only on rising
// - Double rate launches both edges, rising first
// - All 24 combinations with any framing
// - Output clock counts 18, 9, 5, 3
// - Reset framing is idle-low, rising capture
// - Config zero chains input through
module mlsrp_readout #(
  parameter int WORD_BITS = `MLSRP_WORD_BITS,
  parameter int BUF_DEPTH = `MLSRP_BUF_DEPTH
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic word_valid, // Converter offers a sample word
  output logic word_ready, // Buffer can take the word
  input wire logic [WORD_BITS-1:0] word_data, // Sample word, MSB first on the wire
  input wire logic [7:0] output_protocol_config, // Output protocol byte
  input wire logic [1:0] input_framing_field, // SPI polarity and phase select
  input wire logic chip_select_n, // Frame select pin, active low
  input wire logic serial_clock, // Host serial clock pin
  input wire logic serial_data_in, // Host data input pin
  output logic [3:0] output_lanes, // Output lanes zero to three
  output logic return_clock_pin, // Return clock output
  output logic frame_active, // A read frame is running
  output logic word_missing // Frame started with an empty buffer
);

  localparam int WB = WORD_BITS;

  // Pin synchronisers: stage one, stage two, previous stage two
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_d_r;
  logic sdi_s1_r;
  logic sdi_s2_r;

  // Frame state
  mlsrp_pkg::mlsrp_state_t state_r;
  mlsrp_pkg::mlsrp_state_t state_nxt;
  logic [WB-1:0] sreg_r;
  logic [WB-1:0] sreg_nxt;
  logic [3:0] lanes_r;
  logic [3:0] lanes_nxt;
  logic rvs_r;
  logic rvs_nxt;
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [4:0] left_r;
  logic [4:0] left_nxt;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [1:0] framing_r;
  logic [1:0] framing_nxt;
  logic missing_r;
  logic missing_nxt;

  // Buffer drain side
  logic buf_valid;
  logic [WB-1:0] buf_data;
  logic buf_pop;

  // Decoded edges and fields
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [1:0] width;
  logic ddr;
  logic [1:0] csrc;
  logic spi_launch;
  logic spi_capture;
  logic [3:0] half;
  logic [4:0] clocks;
  logic [WB-1:0] load_word;

  // Sample word buffer between the converter and the shifter
  mlsrp_word_buffer #(
    .WIDTH(WB),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data(word_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  // Pin synchronisers, two flops before any logic
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= chip_select_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      sck_s1_r <= serial_clock;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      sdi_s1_r <= serial_data_in;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // Edge decode and settings latched for the running frame
  assign cs_fall = cs_d_r && !cs_s2_r;
  assign cs_rise = !cs_d_r && cs_s2_r;
  assign sck_rise = !sck_d_r && sck_s2_r;
  assign sck_fall = sck_d_r && !sck_s2_r;
  assign width = cfg_r[`MLSRP_WIDTH_MSB:`MLSRP_WIDTH_LSB];
  assign ddr = cfg_r[`MLSRP_RATE_BIT];
  assign csrc = cfg_r[`MLSRP_CSRC_MSB:`MLSRP_CSRC_LSB];
  assign spi_launch = (framing_r[1] ^ framing_r[0]) ? sck_rise : sck_fall;
  assign spi_capture = (framing_r[1] ^ framing_r[0]) ? sck_fall : sck_rise;
  assign buf_pop = (state_r == mlsrp_pkg::MLSRP_IDLE) && cs_fall;
  assign load_word = buf_valid ? buf_data : '0;
  assign half = csrc[1] ? (`MLSRP_INT_HALF << (csrc[0] ? 2 : 1)) : `MLSRP_INT_HALF;

  // Output clocks per read, from lane count and rate
  always_comb
  begin
    unique case ({width, ddr})
      {`MLSRP_WIDTH_DUAL, 1'b0}: clocks = 5'(`MLSRP_SRC_READ_BITS / 2);
      {`MLSRP_WIDTH_DUAL, 1'b1}: clocks = 5'((`MLSRP_SRC_READ_BITS + 3) / 4);
      {`MLSRP_WIDTH_QUAD, 1'b0}: clocks = 5'((`MLSRP_SRC_READ_BITS + 3) / 4);
      {`MLSRP_WIDTH_QUAD, 1'b1}: clocks = 5'((`MLSRP_SRC_READ_BITS + 7) / 8);
      {2'h0, 1'b1}, {2'h1, 1'b1}: clocks = 5'(`MLSRP_SRC_READ_BITS / 2);
      default: clocks = 5'(`MLSRP_SRC_READ_BITS);
    endcase
  end

  // Present the head bits of a word on the lanes for the current width
  function automatic logic [3:0] head_bits(input logic [WB-1:0] w, input logic [1:0] wd);
    logic [3:0] h;
    unique case (wd)
      `MLSRP_WIDTH_DUAL: h = {2'b00, w[WB-2], w[WB-1]};
      `MLSRP_WIDTH_QUAD: h = {w[WB-4], w[WB-3], w[WB-2], w[WB-1]};
      default: h = {3'b000, w[WB-1]};
    endcase
    return h;
  endfunction : head_bits

  // Advance the word past the bits just presented
  function automatic logic [WB-1:0] advance(input logic [WB-1:0] w, input logic [1:0] wd, input logic fill);
    logic [WB-1:0] a;
    unique case (wd)
      `MLSRP_WIDTH_DUAL: a = {w[WB-3:0], 2'b00};
      `MLSRP_WIDTH_QUAD: a = {w[WB-5:0], 4'h0};
      default: a = {w[WB-2:0], fill};
    endcase
    return a;
  endfunction : advance

  // Frame sequencer next values
  always_comb
  begin
    state_nxt = state_r;
    sreg_nxt = sreg_r;
    lanes_nxt = lanes_r;
    rvs_nxt = rvs_r;
    div_nxt = div_r;
    left_nxt = left_r;
    cfg_nxt = cfg_r;
    framing_nxt = framing_r;
    missing_nxt = 1'b0;
    unique case (state_r)
      mlsrp_pkg::MLSRP_IDLE:
      begin
        lanes_nxt = 4'h0;
        rvs_nxt = 1'b0;
        if (cs_fall)
        begin
          // Settings frozen for the frame; phase 1 holds the word until its first launch edge
          cfg_nxt = output_protocol_config;
          framing_nxt = input_framing_field;
          missing_nxt = !buf_valid;
          state_nxt = mlsrp_pkg::MLSRP_SPI;
          sreg_nxt = load_word;
          if (output_protocol_config[`MLSRP_MODE_MSB:`MLSRP_MODE_LSB] == `MLSRP_MODE_SRC)
          begin
            state_nxt = mlsrp_pkg::MLSRP_SRC;
            div_nxt = 4'h0;
            left_nxt = 5'h00;
          end
          else if (!input_framing_field[0])
          begin
            // Phase 0: first bits appear with the frame select
            lanes_nxt = head_bits(load_word, output_protocol_config[`MLSRP_WIDTH_MSB:`MLSRP_WIDTH_LSB]);
            sreg_nxt = advance(load_word, output_protocol_config[`MLSRP_WIDTH_MSB:`MLSRP_WIDTH_LSB], 1'b0);
          end
        end
      end
      mlsrp_pkg::MLSRP_SPI:
      begin
        rvs_nxt = 1'b0;
        if (spi_capture && (cfg_r == `MLSRP_CFG_CHAIN))
        begin
          sreg_nxt[0] = sdi_s2_r; // Input enters at the bottom on each capture edge
        end
        if (cs_rise)
        begin
          state_nxt = mlsrp_pkg::MLSRP_IDLE;
          lanes_nxt = 4'h0;
        end
        else if (spi_launch)
        begin
          // Present the next group; zeros or chained input follow the word
          lanes_nxt = head_bits(sreg_r, width);
          sreg_nxt = advance(sreg_r, width, 1'b0);
        end
      end
      mlsrp_pkg::MLSRP_SRC:
      begin
        if (cs_rise)
        begin
          state_nxt = mlsrp_pkg::MLSRP_IDLE;
          lanes_nxt = 4'h0;
          rvs_nxt = 1'b0;
        end
        else if (csrc == `MLSRP_CSRC_SCLK)
        begin
          // Return clock follows the host clock, data launched on its edges
          rvs_nxt = sck_s2_r;
          if (sck_rise || (ddr && sck_fall))
          begin
            lanes_nxt = head_bits(sreg_r, width);
            sreg_nxt = advance(sreg_r, width, 1'b0);
          end
        end
        else if (left_r == 5'h00 && !rvs_r && div_r == 4'h0)
        begin
          // First tick of the internal source arms the clock count
          left_nxt = clocks;
          div_nxt = half - 4'h1;
        end
        else if (div_r != 4'h0 && left_r != 5'h00)
        begin
          div_nxt = div_r - 4'h1;
        end
        else if (left_r != 5'h00)
        begin
          div_nxt = half - 4'h1;
          rvs_nxt = !rvs_r;
          if (!rvs_r || ddr)
          begin
            lanes_nxt = head_bits(sreg_r, width);
            sreg_nxt = advance(sreg_r, width, 1'b0);
          end
          if (rvs_r)
          begin
            left_nxt = left_r - 5'h01;
            if (left_r == 5'h01)
            begin
              div_nxt = 4'hF; // Parks the generator low until frame end
            end
          end
        end
      end
      default: state_nxt = mlsrp_pkg::MLSRP_IDLE;
    endcase
  end

  // Frame sequencer registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= mlsrp_pkg::MLSRP_IDLE;
      sreg_r <= '0;
      lanes_r <= 4'h0;
      rvs_r <= 1'b0;
      div_r <= 4'h0;
      left_r <= 5'h00;
      cfg_r <= `MLSRP_CFG_RST;
      framing_r <= `MLSRP_FRAMING_RST;
      missing_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sreg_r <= sreg_nxt;
      lanes_r <= lanes_nxt;
      rvs_r <= rvs_nxt;
      div_r <= div_nxt;
      left_r <= left_nxt;
      cfg_r <= cfg_nxt;
      framing_r <= framing_nxt;
      missing_r <= missing_nxt;
    end
  end

  // Outputs straight from flops, except frame_active, decoded from state_r
  assign output_lanes = lanes_r;
  assign return_clock_pin = rvs_r;
  assign frame_active = (state_r != mlsrp_pkg::MLSRP_IDLE);
  assign word_missing = missing_r;

endmodule : mlsrp_readout

`default_nettype wire

// >>> dv/mlsrp_readout_props.sv
`default_nettype none

module mlsrp_readout_props #(
  parameter int WORD_BITS = 20,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic word_valid, // Word offered
  input wire logic word_ready, // Buffer has room
  input wire logic [WORD_BITS-1:0] word_data, // Sample word
  input wire logic [7:0] output_protocol_config, // Protocol byte
  input wire logic [1:0] input_framing_field, // SPI mode
  input wire logic chip_select_n, // Frame select
  input wire logic serial_clock, // Serial clock
  input wire logic serial_data_in, // Daisy input
  input wire logic [3:0] output_lanes, // Lanes
  input wire logic return_clock_pin, // Return clock
  input wire logic frame_active, // Frame running
  input wire logic word_missing // Empty buffer pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic is_src;
  logic rc_d_r;
  logic [4:0] cnt_r;
  logic [4:0] want;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  assign is_src = output_protocol_config[1:0] == 2'h3;
  // Read length in return clocks for width and rate
  always_comb
  begin
    case ({output_protocol_config[4], output_protocol_config[3:2]})
      3'h2, 3'h4, 3'h5: want = 5'h09;
      3'h3, 3'h6: want = 5'h05;
      3'h7: want = 5'h03;
      default: want = 5'h12;
    endcase
  end
  // Count return clock rises inside a frame
  always_ff @(posedge clk)
  begin
    rc_d_r <= return_clock_pin;
    if (!resetn || !frame_active)
      cnt_r <= 5'h00;
    else if (return_clock_pin && !rc_d_r)
      cnt_r <= cnt_r + 5'h01;
  end
  sequence s_idle2;
    !frame_active ##1 !frame_active;
  endsequence
  sequence s_launch;
    frame_active && !chip_select_n && is_src && $changed(output_lanes);
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> output_lanes == 4'h0 && !frame_active)
    else $error("outputs active after reset");
  a_spi_rc_low: assert property (frame_active && !is_src |-> !return_clock_pin)
    else $error("return clock high in SPI frame");
  a_single_lane: assert property (frame_active && !output_protocol_config[3] |-> output_lanes[3:1] == 3'h0)
    else $error("unused lanes active in single width");
  a_dual_lanes: assert property (frame_active && output_protocol_config[3:2] == 2'h2 |-> output_lanes[3:2] == 2'h0)
    else $error("upper lanes active in dual width");
  a_sdr_launch: assert property (s_launch ##0 !output_protocol_config[4] |-> $rose(return_clock_pin))
    else $error("single rate launch off the rising edge");
  a_ddr_launch: assert property (s_launch ##0 output_protocol_config[4] |-> $changed(return_clock_pin))
    else $error("double rate launch off a clock edge");
  a_clock_count: assert property ($fell(frame_active) && is_src |-> cnt_r == want)
    else $error("wrong count of return clocks");
  a_phase1_quiet: assert property ($rose(frame_active) && !is_src && input_framing_field[0] |->
    (output_lanes == 4'h0) [*3])
    else $error("lanes driven before first launch edge");
  a_idle_quiet: assert property (s_idle2 |-> output_lanes == 4'h0 && !return_clock_pin)
    else $error("outputs active while idle");
  a_missing_pulse: assert property (word_missing |=> !word_missing)
    else $error("missing word flag longer than one cycle");
endmodule : mlsrp_readout_props

bind mlsrp_readout mlsrp_readout_props #(.WORD_BITS(WORD_BITS), .BUF_DEPTH(BUF_DEPTH)) mlsrp_readout_props_i (
  .clk(clk), .resetn(resetn), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
  .output_protocol_config(output_protocol_config), .input_framing_field(input_framing_field),
  .chip_select_n(chip_select_n), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
  .output_lanes(output_lanes), .return_clock_pin(return_clock_pin), .frame_active(frame_active),
  .word_missing(word_missing));

`default_nettype wire

// >>> dv/mlsrp_host_model.sv
`default_nettype none

module mlsrp_host_model (
  input wire logic clk, // System clock
  output logic chip_select_n, // Frame select
  output logic serial_clock, // Serial clock
  output logic serial_data_in, // Daisy input data
  input wire logic [3:0] output_lanes, // Lanes from the port
  input wire logic return_clock_pin, // Return clock
  output logic [3:0] got, // Captured group
  output logic got_stb // Capture strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 6; // Half period, above the pin filter
  logic take = 1'b0;
  logic src_on = 1'b0;
  logic ddr_on = 1'b0;
  logic rc_d = 1'b0;
  int n_got = 0;
  initial
  begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    got = 4'h0;
    got_stb = 1'b0;
  end
  // Capture on request, or on return clock launch edges
  always @(posedge clk)
  begin
    rc_d <= return_clock_pin;
    got_stb <= 1'b0;
    if (take || src_on && !chip_select_n && (return_clock_pin != rc_d) && (return_clock_pin || ddr_on))
    begin
      got <= output_lanes;
      got_stb <= 1'b1;
      n_got <= n_got + 1;
    end
  end
  task automatic grab();
    take = 1'b1;
    @(negedge clk);
    take = 1'b0;
  endtask : grab
  task automatic spi_frame(input logic [1:0] mode, input int n, input logic [31:0] pat);
    src_on = 1'b0;
    serial_clock = mode[1]; // Idle level set before the frame
    repeat (H) @(negedge clk);
    chip_select_n = 1'b0;
    repeat (H) @(negedge clk);
    for (int k = 0; k < n; k++) // Host supplies the read clocks
    begin
      serial_data_in = pat[k];
      if (!mode[0]) grab();
      serial_clock = ~mode[1];
      repeat (H) @(negedge clk);
      if (mode[0]) grab();
      serial_clock = mode[1];
      repeat (H) @(negedge clk);
    end
    chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in; // Released line shows no stale bit
    repeat (H) @(negedge clk);
  endtask : spi_frame
  task automatic src_frame(input logic ext, input logic ddr, input int n);
    int goal;
    goal = n_got + (ddr ? 2 * n : n);
    src_on = 1'b1;
    ddr_on = ddr;
    serial_clock = 1'b0;
    repeat (H) @(negedge clk);
    chip_select_n = 1'b0;
    repeat (H) @(negedge clk);
    for (int k = 0; k < n && ext; k++) // Serial source clocks
    begin
      serial_clock = 1'b1;
      repeat (H) @(negedge clk);
      serial_clock = 1'b0;
      repeat (H) @(negedge clk);
    end
    for (int t = 0; t < 400 && n_got != goal; t++) @(negedge clk);
    repeat (4) @(negedge clk);
    chip_select_n = 1'b1;
    repeat (H) @(negedge clk);
  endtask : src_frame
endmodule : mlsrp_host_model

`default_nettype wire

// >>> dv/mlsrp_readout_bench.sv
`default_nettype none

module mlsrp_readout_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, word_valid, word_ready, chip_select_n, serial_clock, serial_data_in;
  logic [19:0] word_data;
  logic [7:0] output_protocol_config;
  logic [1:0] input_framing_field;
  logic [3:0] output_lanes, got;
  logic return_clock_pin, frame_active, word_missing, got_stb;
  logic [3:0] exp_q[$];
  int err_count = 0;
  int checks = 0;
  int seed = 85;
  int miss_n = 0;
  // System clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  mlsrp_readout mlsrp_readout_i (.clk(clk), .resetn(resetn), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .output_protocol_config(output_protocol_config), .input_framing_field(input_framing_field),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .output_lanes(output_lanes), .return_clock_pin(return_clock_pin), .frame_active(frame_active),
    .word_missing(word_missing));
  mlsrp_host_model mlsrp_host_model_i (.clk(clk), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .output_lanes(output_lanes), .return_clock_pin(return_clock_pin),
    .got(got), .got_stb(got_stb));
  task automatic bad(input string msg);
    err_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : bad
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Lane group g of a word, lane zero holds the highest bit
  function automatic logic [3:0] grp(input logic [19:0] w, input int wd, input int g);
    logic [3:0] v;
    int idx;
    v = 4'h0;
    for (int i = 0; i < wd; i++)
    begin
      idx = 19 - g * wd - i;
      if (idx >= 0) v[i] = w[idx];
    end
    return v;
  endfunction : grp
  task automatic note(input logic [19:0] w, input int wd, input int n, input logic [31:0] pat, input logic chain);
    for (int g = 0; g < n; g++)
      exp_q.push_back(chain && g >= 20 ? {3'h0, pat[g-20]} : grp(w, wd, g));
  endtask : note
  task automatic load(input logic [19:0] w);
    word_data = w;
    word_valid = 1'b1;
    @(negedge clk);
    word_valid = 1'b0;
  endtask : load
  // Compare each captured group with the oldest note
  always @(posedge clk)
  begin
    if (word_missing === 1'b1) miss_n++;
    if (got_stb === 1'b1)
    begin
      checks++;
      if (exp_q.size() == 0) bad("unexpected lane group");
      else if (got !== exp_q.pop_front()) bad("lane group differs");
    end
  end
  // Main sequence
  initial
  begin
    int wd;
    int n;
    logic [7:0] cfg;
    logic [19:0] w0;
    logic [19:0] w1;
    resetn = 1'b0;
    word_valid = 1'b0;
    word_data = 20'h00000;
    output_protocol_config = 8'h00;
    input_framing_field = 2'h0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    w0 = 20'($random(seed));
    w1 = 20'($random(seed));
    word_valid = 1'b1;
    word_data = w0;
    @(negedge clk);
    word_data = w1;
    @(negedge clk);
    word_data = ~w1;
    @(negedge clk);
    checks++;
    if (word_ready !== 1'b0) bad("buffer took a third word");
    word_valid = 1'b0;
    output_protocol_config = 8'h0C;
    note(w0, 4, 6, 32'h0, 1'b0);
    mlsrp_host_model_i.spi_frame(2'h0, 6, 32'h0);
    repeat (20) @(negedge clk);
    note(w1, 4, 6, 32'h0, 1'b0);
    mlsrp_host_model_i.spi_frame(2'h0, 6, 32'h0);
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 3; c++)
      begin
        wd = 1 << c;
        cfg = c == 0 ? 8'h00 : c == 1 ? 8'h08 : 8'h0C;
        n = 20 / wd + (c == 0 ? 3 : 1);
        w0 = 20'($random(seed));
        w1 = 20'($random(seed));
        output_protocol_config = cfg;
        input_framing_field = 2'(m);
        load(w0);
        note(w0, wd, n, {12'h000, w1}, c == 0);
        mlsrp_host_model_i.spi_frame(2'(m), n, {12'h000, w1});
      end
    output_protocol_config = 8'h08;
    input_framing_field = 2'h0;
    note(20'h00000, 2, 11, 32'h0, 1'b0);
    mlsrp_host_model_i.spi_frame(2'h0, 11, 32'h0);
    checks++;
    if (miss_n !== 1) bad("no missing word pulse");
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 3; c++)
        for (int r = 0; r < 2; r++)
        begin
          wd = 1 << c;
          n = (18 + wd * (r + 1) - 1) / (wd * (r + 1));
          output_protocol_config = {2'(s), 1'b0, 1'(r), c == 0 ? 2'h0 : 2'(c + 1), 2'h3};
          input_framing_field = 2'($random(seed));
          w0 = 20'($random(seed));
          load(w0);
          note(w0, wd, n * (r + 1), 32'h0, 1'b0);
          mlsrp_host_model_i.src_frame(s == 0, 1'(r), n);
        end
    checks++;
    if (exp_q.size() != 0) bad("lane groups never arrived");
    final_report();
  end
  // Watchdog against a hang
  initial
  begin
    #400000;
    err_count++;
    final_report();
  end
endmodule : mlsrp_readout_bench

`default_nettype wire
